/* hdl/regbank_pkg.sv */
// Purpose: shared constants and helpers for the peripheral register bank
// Assumes: 8-bit registers reached through a plain indexed access port
// Notes: register indices, masks and reset values live here only
//
// Overview of operation
// - a read-write bit reads back its stored value and takes the written value on a write.
// - a read-only bit reads its current value and ignores every write.
// - a write-only bit accepts writes and its read value is undefined for software.
// - reserved bits and fields always read as zero.
// - registers take their reset value on power-on and on a soft reset, debug control excepted.
// - a one written to the set alias sets that bit in the base register.
// - a one written to the clear alias clears that bit in the base register.
// - the base register and each alias read back the same current contents.
// - the supply monitors hold the whole system in reset while the supply is low.
package regbank_pkg;

  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int IDX_W = 4;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_STATUS = 4'h1;
  localparam logic [3:0] IDX_CMD = 4'h2;
  localparam logic [3:0] IDX_OUT = 4'h4;
  localparam logic [3:0] IDX_OUT_SET = 4'h5;
  localparam logic [3:0] IDX_BIT_CLEAR_ALIAS = 4'h6;
  localparam logic [3:0] IDX_BIT_INVERT_ALIAS = 4'h7;
  localparam logic [3:0] IDX_DBG = 4'h8;

  // ----------------------------------------------------------------
  // masks (implemented bits) and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_MASK = 8'h0F;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STATUS_MASK = 8'h3F;
  localparam logic [7:0] CMD_MASK = 8'h0F;
  localparam logic [7:0] OUT_RST = 8'h00;
  localparam logic [7:0] DBG_MASK = 8'h07;
  localparam logic [7:0] DBG_RST = 8'h00;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam int CMD_SOFT_RST_BIT = 0;

  typedef enum {ALIAS_WRITE, ALIAS_SET, ALIAS_CLEAR, ALIAS_INVERT} alias_e;

  // next base value for a write through the base register or one of its aliases
  function automatic logic [7:0] alias_apply(input logic [7:0] base, input logic [7:0] wd,
                                             input alias_e kind);
    logic [7:0] res;
    res = base;
    case (kind)
      ALIAS_WRITE: res = wd;
      ALIAS_SET: res = base | wd;
      ALIAS_CLEAR: res = base & ~wd;
      ALIAS_INVERT: res = base ^ wd;
      default: res = base;
    endcase
    return res;
  endfunction : alias_apply

endpackage : regbank_pkg

/* hdl/supply_status_if.sv */
`timescale 1ns/10ps
// Purpose: carries the filtered supply state from the monitor to the bank
// Assumes: single clock domain
// Notes: hold is high while either supply check reports low
interface supply_status_if;
  logic por_ok;
  logic drop_ok;
  logic hold;

  modport mon (output por_ok, output drop_ok, output hold);
  modport core (input por_ok, input drop_ok, input hold);
endinterface : supply_status_if

/* hdl/supply_drop_monitor.sv */
`timescale 1ns/10ps
// Purpose: filters the two supply comparator pins and raises the system hold
// Assumes: comparator pins are asynchronous to clock
// Notes: a pin change counts only once the second and third stages agree
module supply_drop_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic ce,
  input wire logic sys_rst,
  // comparator pins, high while the supply is above threshold
  input wire logic por_above_pin,
  input wire logic drop_above_pin,
  // filtered state
  supply_status_if.mon sup
);

  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] ok_q;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= 2'h0;
      s2_q <= 2'h0;
      s3_q <= 2'h0;
    end else if (ce) begin
      s1_q <= {drop_above_pin, por_above_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------------
  // filtered level and hold
  // ----------------------------------------------------------------
  // starts low so the system stays held until both supplies are seen good
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ok_q <= 2'h0;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          ok_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign sup.por_ok = ok_q[0];
  assign sup.drop_ok = ok_q[1];
  assign sup.hold = ~(ok_q[0] & ok_q[1]);

  default clocking mon_cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_low_supply_holds: assert property ((ce && s2_q[1] == 1'b0 && s3_q[1] == 1'b0)
    |=> sup.hold) else $error("supply drop did not hold the system");
  a_glitch_ignored: assert property ((ce && s2_q[0] != s3_q[0]) |=> $stable(ok_q[0]))
    else $error("unsettled pin changed the filtered level");

endmodule : supply_drop_monitor

/* hdl/register_access_bank.sv */
`timescale 1ns/10ps
// Purpose: peripheral register bank with read-write, read-only, write-only and alias registers
// Assumes: one access per cycle through the indexed port, all inputs but the pins on clock
// Notes: read data appears one cycle after the read strobe
module register_access_bank (
  // clock and reset
  input wire logic clock,
  input wire logic ce,
  input wire logic sys_rst,
  // supply comparator pins
  input wire logic por_above_pin,
  input wire logic drop_above_pin,
  // register access port
  input wire logic acc_wr,
  input wire logic acc_rd,
  input wire logic [3:0] acc_idx,
  input wire logic [7:0] acc_wdata,
  output logic [7:0] acc_rdata,
  output logic acc_rvalid,
  // block side
  input wire logic [7:0] status_in,
  output logic [7:0] ctrl_out,
  output logic [7:0] out_bits,
  output logic [7:0] dbg_ctrl,
  output logic [7:0] cmd_strobe,
  output logic sys_hold
);

  supply_status_if sup ();

  supply_drop_monitor u_mon (
    .clock(clock),
    .ce(ce),
    .sys_rst(sys_rst),
    .por_above_pin(por_above_pin),
    .drop_above_pin(drop_above_pin),
    .sup(sup)
  );

  logic [7:0] ctrl_q;
  logic [7:0] out_q;
  logic [7:0] dbg_q;
  logic [7:0] cmd_q;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic hold_q;
  logic [7:0] rdata_d;
  logic soft_req;
  logic out_hit;
  regbank_pkg::alias_e out_kind;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  assign soft_req = acc_wr && acc_idx == regbank_pkg::IDX_CMD
                    && acc_wdata[regbank_pkg::CMD_SOFT_RST_BIT];

  always_comb begin
    out_hit = acc_wr;
    out_kind = regbank_pkg::ALIAS_WRITE;
    if (acc_idx == regbank_pkg::IDX_OUT) begin
      out_kind = regbank_pkg::ALIAS_WRITE;
    end else if (acc_idx == regbank_pkg::IDX_OUT_SET) begin
      out_kind = regbank_pkg::ALIAS_SET;
    end else if (acc_idx == regbank_pkg::IDX_BIT_CLEAR_ALIAS) begin
      out_kind = regbank_pkg::ALIAS_CLEAR;
    end else if (acc_idx == regbank_pkg::IDX_BIT_INVERT_ALIAS) begin
      out_kind = regbank_pkg::ALIAS_INVERT;
    end else begin
      out_hit = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read-write control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= regbank_pkg::CTRL_RST;
    end else if (ce) begin
      if (sup.hold || soft_req) begin
        ctrl_q <= regbank_pkg::CTRL_RST;
      end else if (acc_wr && acc_idx == regbank_pkg::IDX_CTRL) begin
        ctrl_q <= acc_wdata & regbank_pkg::CTRL_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // output register and its aliases
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      out_q <= regbank_pkg::OUT_RST;
    end else if (ce) begin
      if (sup.hold || soft_req) begin
        out_q <= regbank_pkg::OUT_RST;
      end else if (out_hit) begin
        out_q <= regbank_pkg::alias_apply(out_q, acc_wdata, out_kind);
      end
    end
  end

  // ----------------------------------------------------------------
  // debug control, kept across a soft reset
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_q <= regbank_pkg::DBG_RST;
    end else if (ce) begin
      if (sup.hold) begin
        dbg_q <= regbank_pkg::DBG_RST;
      end else if (acc_wr && acc_idx == regbank_pkg::IDX_DBG) begin
        dbg_q <= acc_wdata & regbank_pkg::DBG_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // write-only command strobes
  // ----------------------------------------------------------------
  // accepted as a one-cycle pulse, never stored
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q <= 8'h00;
    end else if (ce) begin
      if (acc_wr && acc_idx == regbank_pkg::IDX_CMD && !sup.hold) begin
        cmd_q <= acc_wdata & regbank_pkg::CMD_MASK;
      end else begin
        cmd_q <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (acc_idx == regbank_pkg::IDX_CTRL) begin
      rdata_d = ctrl_q & regbank_pkg::CTRL_MASK;
    end else if (acc_idx == regbank_pkg::IDX_STATUS) begin
      rdata_d = status_in & regbank_pkg::STATUS_MASK;
    end else if (out_hit || (acc_idx >= regbank_pkg::IDX_OUT
                             && acc_idx <= regbank_pkg::IDX_BIT_INVERT_ALIAS)) begin
      rdata_d = out_q;
    end else if (acc_idx == regbank_pkg::IDX_DBG) begin
      rdata_d = dbg_q & regbank_pkg::DBG_MASK;
    end else begin
      rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q <= regbank_pkg::RDATA_RST;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= acc_rd;
      if (acc_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hold_q <= 1'b1;
    end else if (ce) begin
      hold_q <= sup.hold;
    end
  end

  assign acc_rdata = rdata_q;
  assign acc_rvalid = rvalid_q;
  assign ctrl_out = ctrl_q;
  assign out_bits = out_q;
  assign dbg_ctrl = dbg_q;
  assign cmd_strobe = cmd_q;
  assign sys_hold = hold_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking bank_cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_live;
    ce && !sup.hold && !soft_req;
  endsequence
  sequence s_soft;
    ce && soft_req && !sup.hold;
  endsequence
  sequence s_rd(logic [3:0] idx);
    ce && acc_rd && acc_idx == idx;
  endsequence
  sequence s_wr(logic [3:0] idx);
    acc_wr && acc_idx == idx;
  endsequence

  a_ctrl_rw_store: assert property ((s_live and s_wr(regbank_pkg::IDX_CTRL))
    |=> ctrl_q == ($past(acc_wdata) & regbank_pkg::CTRL_MASK))
    else $error("control write not stored");
  a_status_read_only: assert property (s_rd(regbank_pkg::IDX_STATUS)
    |=> acc_rvalid && acc_rdata == ($past(status_in) & regbank_pkg::STATUS_MASK))
    else $error("status read wrong");
  // a back-to-back command write may legally keep the strobe up
  a_cmd_write_only: assert property ((s_live and s_wr(regbank_pkg::IDX_CMD))
    |=> cmd_strobe == ($past(acc_wdata) & regbank_pkg::CMD_MASK)
    ##1 (!ce || ($past(acc_wr) && $past(acc_idx) == regbank_pkg::IDX_CMD)
         || cmd_strobe == 8'h00))
    else $error("command strobe not a single pulse");
  a_reserved_zero: assert property (s_rd(regbank_pkg::IDX_CTRL)
    |=> acc_rdata[7:4] == 4'h0 && acc_rdata == $past(ctrl_q))
    else $error("control read back wrong");
  a_soft_reset_keep: assert property (s_soft
    |=> ctrl_q == regbank_pkg::CTRL_RST && out_q == regbank_pkg::OUT_RST
        && dbg_q == $past(dbg_q))
    else $error("soft reset result wrong");
  a_alias_set_bits: assert property ((s_live and s_wr(regbank_pkg::IDX_OUT_SET))
    |=> out_q == ($past(out_q) | $past(acc_wdata)))
    else $error("set alias result wrong");
  a_alias_clear_bits: assert property (
    (s_live and s_wr(regbank_pkg::IDX_BIT_CLEAR_ALIAS))
    |=> out_q == ($past(out_q) & ~$past(acc_wdata)))
    else $error("clear alias result wrong");
  a_alias_same_read: assert property (
    (ce && acc_rd && acc_idx >= regbank_pkg::IDX_OUT
     && acc_idx <= regbank_pkg::IDX_BIT_INVERT_ALIAS)
    |=> acc_rdata == $past(out_q))
    else $error("alias read differs from base");
  a_hold_resets_all: assert property ((ce && sup.hold)
    |=> ctrl_q == regbank_pkg::CTRL_RST && dbg_q == regbank_pkg::DBG_RST && sys_hold
        && out_q == regbank_pkg::OUT_RST)
    else $error("supply hold did not reset the bank");
  a_supply_low_holds: assert property ((ce && !(sup.por_ok && sup.drop_ok))
    |=> sys_hold && ctrl_q == regbank_pkg::CTRL_RST)
    else $error("low supply level did not hold the bank");
  a_alias_invert_bits: assert property (
    (s_live and s_wr(regbank_pkg::IDX_BIT_INVERT_ALIAS))
    |=> out_q == ($past(out_q) ^ $past(acc_wdata)))
    else $error("invert alias result wrong");
  a_alias_zero_keeps: assert property (
    (s_live and (out_hit && out_kind != regbank_pkg::ALIAS_WRITE && acc_wdata == 8'h00))
    |=> $stable(out_q))
    else $error("zero alias write changed base");

endmodule : register_access_bank

/* bench/register_access_bank_tb.sv */
// Purpose: self-checking bench for the peripheral register bank
// Assumes: all inputs driven on the falling clock edge, ce lowered once to freeze the bank
// Notes: write-only reads are not compared, their value is undefined for software
`timescale 1ns/10ps
module register_access_bank_tb;

  // ----------------------------------------------------------------
  // design connections
  // ----------------------------------------------------------------
  logic clock;
  logic ce;
  logic sys_rst;
  logic por_above_pin;
  logic drop_above_pin;
  logic acc_wr;
  logic acc_rd;
  logic [3:0] acc_idx;
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;
  logic acc_rvalid;
  logic [7:0] status_in;
  logic [7:0] ctrl_out;
  logic [7:0] out_bits;
  logic [7:0] dbg_ctrl;
  logic [7:0] cmd_strobe;
  logic sys_hold;
  int err_total;
  int checked;

  register_access_bank uut (
    .clock(clock), .ce(ce), .sys_rst(sys_rst),
    .por_above_pin(por_above_pin), .drop_above_pin(drop_above_pin),
    .acc_wr(acc_wr), .acc_rd(acc_rd), .acc_idx(acc_idx), .acc_wdata(acc_wdata),
    .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid), .status_in(status_in),
    .ctrl_out(ctrl_out), .out_bits(out_bits), .dbg_ctrl(dbg_ctrl),
    .cmd_strobe(cmd_strobe), .sys_hold(sys_hold)
  );

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] idx, input logic [7:0] data);
    @(negedge clock);
    acc_wr = 1'b1;
    acc_idx = idx;
    acc_wdata = data;
    @(negedge clock);
    acc_wr = 1'b0;
  endtask : wr

  // rvalid and data are registered, so both are settled at the next falling edge
  task automatic rd_chk(input logic [3:0] idx, input logic [7:0] exp);
    @(negedge clock);
    acc_rd = 1'b1;
    acc_idx = idx;
    @(negedge clock);
    acc_rd = 1'b0;
    chk({7'h00, acc_rvalid}, 8'h01);
    chk(acc_rdata, exp);
    // rvalid is a single pulse while the read data stays put until the next read
    @(negedge clock);
    chk({7'h00, acc_rvalid}, 8'h00);
    chk(acc_rdata, exp);
  endtask : rd_chk

  // the pin filter takes about five edges; twenty leaves margin without hiding a stuck hold
  task automatic wait_hold(input logic level);
    int n;
    n = 0;
    while (sys_hold !== level && n < 20) begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, sys_hold}, {7'h00, level});
  endtask : wait_hold

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_up;
    wait_hold(1'b0);
    rd_chk(regbank_pkg::IDX_CTRL, regbank_pkg::CTRL_RST);
    rd_chk(regbank_pkg::IDX_OUT, regbank_pkg::OUT_RST);
    rd_chk(regbank_pkg::IDX_DBG, regbank_pkg::DBG_RST);
    rd_chk(4'h3, 8'h00);
    $display("test power_up done");
  endtask : t_power_up

  task automatic t_read_write;
    wr(regbank_pkg::IDX_CTRL, 8'h05);
    chk(ctrl_out, 8'h05);
    rd_chk(regbank_pkg::IDX_CTRL, 8'h05);
    wr(regbank_pkg::IDX_CTRL, 8'h0A);
    rd_chk(regbank_pkg::IDX_CTRL, 8'h0A);
    wr(regbank_pkg::IDX_DBG, 8'h07);
    rd_chk(regbank_pkg::IDX_DBG, 8'h07);
    chk(dbg_ctrl, 8'h07);
    // ce low freezes the bank, so this write must not land
    ce = 1'b0;
    wr(regbank_pkg::IDX_CTRL, 8'h03);
    chk(ctrl_out, 8'h0A);
    ce = 1'b1;
    $display("test read_write done");
  endtask : t_read_write

  task automatic t_read_only;
    status_in = 8'hFF;
    wr(regbank_pkg::IDX_STATUS, 8'h00);
    rd_chk(regbank_pkg::IDX_STATUS, regbank_pkg::STATUS_MASK);
    status_in = 8'h15;
    rd_chk(regbank_pkg::IDX_STATUS, 8'h15);
    $display("test read_only done");
  endtask : t_read_only

  task automatic t_write_only;
    wr(regbank_pkg::IDX_CMD, 8'h0E);
    chk(cmd_strobe, 8'h0E);
    chk(ctrl_out, 8'h0A);
    @(negedge clock);
    chk(cmd_strobe, 8'h00);
    wr(regbank_pkg::IDX_OUT, 8'h81);
    wr(regbank_pkg::IDX_CMD, 8'h01);
    chk(cmd_strobe, 8'h01);
    chk(ctrl_out, regbank_pkg::CTRL_RST);
    chk(out_bits, regbank_pkg::OUT_RST);
    chk(dbg_ctrl, 8'h07);
    $display("test write_only done");
  endtask : t_write_only

  task automatic t_alias;
    wr(regbank_pkg::IDX_OUT, 8'h5A);
    wr(regbank_pkg::IDX_OUT_SET, 8'h03);
    chk(out_bits, 8'h5B);
    rd_chk(regbank_pkg::IDX_OUT_SET, 8'h5B);
    wr(regbank_pkg::IDX_BIT_CLEAR_ALIAS, 8'h18);
    chk(out_bits, 8'h43);
    rd_chk(regbank_pkg::IDX_BIT_CLEAR_ALIAS, 8'h43);
    wr(regbank_pkg::IDX_BIT_INVERT_ALIAS, 8'hF0);
    chk(out_bits, 8'hB3);
    rd_chk(regbank_pkg::IDX_BIT_INVERT_ALIAS, 8'hB3);
    wr(regbank_pkg::IDX_OUT_SET, 8'h00);
    wr(regbank_pkg::IDX_BIT_CLEAR_ALIAS, 8'h00);
    wr(regbank_pkg::IDX_BIT_INVERT_ALIAS, 8'h00);
    rd_chk(regbank_pkg::IDX_OUT, 8'hB3);
    $display("test alias done");
  endtask : t_alias

  task automatic t_supply;
    wr(regbank_pkg::IDX_CTRL, 8'h09);
    drop_above_pin = 1'b0;
    wait_hold(1'b1);
    chk(ctrl_out, regbank_pkg::CTRL_RST);
    chk(dbg_ctrl, regbank_pkg::DBG_RST);
    wr(regbank_pkg::IDX_CTRL, 8'h06);
    rd_chk(regbank_pkg::IDX_CTRL, regbank_pkg::CTRL_RST);
    drop_above_pin = 1'b1;
    wait_hold(1'b0);
    por_above_pin = 1'b0;
    wait_hold(1'b1);
    chk(out_bits, regbank_pkg::OUT_RST);
    por_above_pin = 1'b1;
    wait_hold(1'b0);
    wr(regbank_pkg::IDX_CTRL, 8'h06);
    chk(ctrl_out, 8'h06);
    $display("test supply done");
  endtask : t_supply

  // ----------------------------------------------------------------
  // verdict and run control
  // ----------------------------------------------------------------
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // the whole run needs about a hundred cycles
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    $display("watchdog expired at %0t ns", $time);
    finish_test();
  end

  initial begin
    err_total = 0;
    checked = 0;
    ce = 1'b1;
    sys_rst = 1'b1;
    por_above_pin = 1'b1;
    drop_above_pin = 1'b1;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_idx = 4'h0;
    acc_wdata = 8'h00;
    status_in = 8'h00;
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    t_power_up();
    t_read_write();
    t_read_only();
    t_write_only();
    t_alias();
    t_supply();
    finish_test();
  end

endmodule : register_access_bank_tb
